// *** tws_pkg.sv ***
// Shared constants, register layout and types of the two-wire slave block
package tws_pkg;

    // Register byte offsets on the Wishbone bus
    localparam logic [4:0] OFS_OWN_ADDR = 5'h00;
    localparam logic [4:0] OFS_CTRL = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_DATA = 5'h0c;

    // Reset values
    localparam logic [7:0] OWN_ADDR_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hff;

    // Status codes, prescaler bits always zero
    localparam logic [7:0] ST_IDLE = 8'hf8;
    localparam logic [7:0] ST_SR_OWN = 8'h60;
    localparam logic [7:0] ST_SR_ARB_OWN = 8'h68;
    localparam logic [7:0] ST_SR_GC = 8'h70;
    localparam logic [7:0] ST_SR_ARB_GC = 8'h78;
    localparam logic [7:0] ST_SR_DATA_ACK = 8'h80;
    localparam logic [7:0] ST_SR_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
    localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
    localparam logic [7:0] ST_SR_STOP = 8'ha0;
    localparam logic [7:0] ST_ST_OWN = 8'ha8;
    localparam logic [7:0] ST_ST_ARB_OWN = 8'hb0;
    localparam logic [7:0] ST_ST_DATA_ACK = 8'hb8;
    localparam logic [7:0] ST_ST_DATA_NACK = 8'hc0;
    localparam logic [7:0] ST_ST_LAST_ACK = 8'hc8;

    // Bus framing
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_BIT = 4'h9;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic flag;
        logic ack_en;
        logic start_req;
        logic stop_req;
        logic wcol;
        logic en;
        logic rsvd;
        logic ie;
    } tws_ctrl_s;

endpackage

// *** tws_slave.sv ***
// Two-wire bus slave with receive and transmit modes behind a Wishbone register file
`timescale 1ns/1ps
// Function
// - After general-call data ACKed, next byte gets ACK if acknowledge_enable, else NACK.
// - After general-call data NACKed, clearing the flag drops to not-addressed mode.
// - Not-addressed with acknowledge_enable zero: no own or general call recognition.
// - With acknowledge_enable one: own address matched, general call only if enabled.
// - Pending start_request leaving slave mode sends START once the bus is free.
// - STOP or repeated START while addressed in receive mode reports stop status, then drops out.
// - Match upper seven own-address bits; general call needs own-address bit zero set.
// - Matched address with read bit enters transmit, otherwise receive mode.
// - After own address and direction, flag sets with a valid status code.
// - Arbitration lost then addressed for read enters transmit with its status.
// - Acknowledge_enable cleared during transmit makes the current byte the last.
// - After last byte, NACK or ACK status follows the master's response.
// - After last byte, drop to not-addressed and keep SDA released.
// - Acknowledge_enable zero isolates; setting it resumes address recognition anytime.
// - In deep sleep with acknowledge_enable, address match still happens and wakes.
// - After wake-up match, SCL stays low until software clears the flag.
// - Own read address: ACK, report status, send loaded byte, last if acknowledge off.
// - Transmitted byte ACKed by master: report status, then send next loaded byte.
module tws_slave
    import tws_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic arb_lost_i,
    input wire logic sleep_i,
    output logic wake_o,
    output logic master_start_o,
    output logic irq_o
);
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX, S_HOLD} tws_state_e;
    tws_state_e state_r;
    tws_ctrl_s ctrl_r;
    tws_ctrl_s ctrl_rd;
    logic [7:0] own_addr_r, status_r, data_r, shift_r, tx_shift_r, rd_c;
    logic [3:0] cnt_r;
    logic flag_r, wcol_r, is_tx_r, is_gc_r, arb_r, ack_send_r, last_r, m_ack_r, done_r;
    logic start_pending_r, bus_busy_r;
    logic scl_meta_r, scl_sync_r, scl_prev_r, sda_meta_r, sda_sync_r, sda_prev_r;
    logic scl_rise_c, scl_fall_c, start_det_c, stop_det_c, own_hit_c, gc_hit_c;
    logic wb_req_c, wr_c, flag_clr_c, start_go_c;
    // Open-drain pins only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    // Pin synchronisers and one-cycle history for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_meta_r <= 1'b1;
            scl_sync_r <= 1'b1;
            scl_prev_r <= 1'b1;
            sda_meta_r <= 1'b1;
            sda_sync_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_meta_r <= scl_i;
            scl_sync_r <= scl_meta_r;
            scl_prev_r <= scl_sync_r;
            sda_meta_r <= sda_i;
            sda_sync_r <= sda_meta_r;
            sda_prev_r <= sda_sync_r;
        end
    end
    assign scl_rise_c = scl_sync_r & ~scl_prev_r;
    assign scl_fall_c = ~scl_sync_r & scl_prev_r;
    assign start_det_c = scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
    assign stop_det_c = scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;
    // Address recognition, gated by acknowledge enable
    assign own_hit_c = ctrl_r.ack_en && (shift_r[6:0] == own_addr_r[7:1]);
    assign gc_hit_c = ctrl_r.ack_en && own_addr_r[0] && (shift_r[6:0] == GEN_CALL_ADDR)
        && !sda_sync_r;
    // Wishbone decode
    assign wb_req_c = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_c = wb_req_c & wb_we_i & wb_sel_i[0];
    assign flag_clr_c = wr_c && (wb_adr_i == OFS_CTRL) && wb_dat_i[7];
    assign start_go_c = start_pending_r & ~bus_busy_r;
    always_comb begin
        ctrl_rd = ctrl_r;
        ctrl_rd.flag = flag_r;
        ctrl_rd.wcol = wcol_r;
        unique case (wb_adr_i)
            OFS_OWN_ADDR: rd_c = own_addr_r;
            OFS_CTRL: rd_c = ctrl_rd;
            OFS_STATUS: rd_c = flag_r ? status_r : ST_IDLE;
            OFS_DATA: rd_c = data_r;
            default: rd_c = 8'h00;
        endcase
    end
    // Bus slave answer, one wait state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req_c;
            wb_dat_o <= wb_req_c ? {24'h00_0000, rd_c} : 32'h0000_0000;
        end
    end
    // Software-owned registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            own_addr_r <= OWN_ADDR_RST;
            ctrl_r <= CTRL_RST;
        end else begin
            if (wr_c && wb_adr_i == OFS_OWN_ADDR) begin
                own_addr_r <= wb_dat_i[7:0];
            end
            if (wr_c && wb_adr_i == OFS_CTRL) begin
                ctrl_r <= wb_dat_i[7:0];
                ctrl_r.flag <= 1'b0;
                ctrl_r.wcol <= 1'b0;
                ctrl_r.rsvd <= 1'b0;
            end
            if (start_go_c) begin
                ctrl_r.start_req <= 1'b0;
            end
        end
    end
    // Bus-facing state machine, flag, status and data byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            status_r <= ST_IDLE;
            data_r <= DATA_RST;
            shift_r <= 8'h00;
            tx_shift_r <= 8'hff;
            cnt_r <= 4'h0;
            flag_r <= 1'b0;
            wcol_r <= 1'b0;
            is_tx_r <= 1'b0;
            is_gc_r <= 1'b0;
            arb_r <= 1'b0;
            ack_send_r <= 1'b0;
            last_r <= 1'b0;
            m_ack_r <= 1'b0;
            done_r <= 1'b0;
            start_pending_r <= 1'b0;
            bus_busy_r <= 1'b0;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            if (flag_clr_c) begin
                flag_r <= 1'b0;
            end
            if (wr_c && wb_adr_i == OFS_DATA) begin
                if (flag_r) begin
                    data_r <= wb_dat_i[7:0];
                    wcol_r <= 1'b0;
                end else begin
                    wcol_r <= 1'b1;
                end
            end
            if (start_go_c) begin
                start_pending_r <= 1'b0;
            end
            if (start_det_c) begin
                bus_busy_r <= 1'b1;
            end else if (stop_det_c) begin
                bus_busy_r <= 1'b0;
            end
            if (!sleep_i) begin
                wake_o <= 1'b0;
            end
            if (!ctrl_r.en) begin
                state_r <= S_IDLE;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
            end else if ((start_det_c || stop_det_c) && state_r != S_HOLD) begin
                if (state_r == S_RX) begin
                    flag_r <= 1'b1;
                    status_r <= ST_SR_STOP;
                    start_pending_r <= ctrl_r.start_req;
                end
                state_r <= start_det_c ? S_ADDR : S_IDLE;
                cnt_r <= 4'h0;
                sda_oe_o <= 1'b0;
            end else begin
                unique case (state_r)
                    S_IDLE: sda_oe_o <= 1'b0;
                    S_ADDR: begin
                        if (scl_rise_c) begin
                            shift_r <= {shift_r[6:0], sda_sync_r};
                            cnt_r <= cnt_r + 4'h1;
                            if (cnt_r == BYTE_BITS - 4'h1) begin
                                if (own_hit_c || gc_hit_c) begin
                                    is_tx_r <= own_hit_c && sda_sync_r;
                                    is_gc_r <= gc_hit_c && !own_hit_c;
                                    arb_r <= arb_lost_i;
                                    if (sleep_i) begin
                                        wake_o <= 1'b1;
                                    end
                                end else begin
                                    state_r <= S_IDLE;
                                end
                            end
                        end
                        if (scl_fall_c && cnt_r == BYTE_BITS) begin
                            sda_oe_o <= 1'b1;
                        end
                        if (scl_fall_c && cnt_r == ACK_BIT) begin
                            sda_oe_o <= 1'b0;
                            flag_r <= 1'b1;
                            scl_oe_o <= 1'b1;
                            done_r <= 1'b0;
                            cnt_r <= 4'h0;
                            state_r <= S_HOLD;
                            if (is_tx_r) begin
                                status_r <= arb_r ? ST_ST_ARB_OWN : ST_ST_OWN;
                            end else if (is_gc_r) begin
                                status_r <= arb_r ? ST_SR_ARB_GC : ST_SR_GC;
                            end else begin
                                status_r <= arb_r ? ST_SR_ARB_OWN : ST_SR_OWN;
                            end
                        end
                    end
                    S_RX: begin
                        if (cnt_r < BYTE_BITS) begin
                            ack_send_r <= ctrl_r.ack_en;
                        end
                        if (scl_rise_c) begin
                            shift_r <= (cnt_r < BYTE_BITS) ? {shift_r[6:0], sda_sync_r} : shift_r;
                            cnt_r <= cnt_r + 4'h1;
                        end
                        if (scl_fall_c && cnt_r == BYTE_BITS) begin
                            sda_oe_o <= ack_send_r;
                        end
                        if (scl_fall_c && cnt_r == ACK_BIT) begin
                            sda_oe_o <= 1'b0;
                            data_r <= shift_r;
                            flag_r <= 1'b1;
                            scl_oe_o <= 1'b1;
                            done_r <= !ack_send_r;
                            cnt_r <= 4'h0;
                            state_r <= S_HOLD;
                            if (is_gc_r) begin
                                status_r <= ack_send_r ? ST_GC_DATA_ACK : ST_GC_DATA_NACK;
                            end else begin
                                status_r <= ack_send_r ? ST_SR_DATA_ACK : ST_SR_DATA_NACK;
                            end
                        end
                    end
                    S_TX: begin
                        if (!ctrl_r.ack_en) begin
                            last_r <= 1'b1;
                        end
                        if (scl_rise_c) begin
                            cnt_r <= cnt_r + 4'h1;
                            if (cnt_r == BYTE_BITS) begin
                                m_ack_r <= !sda_sync_r;
                            end
                        end
                        if (scl_fall_c && cnt_r > 4'h0 && cnt_r < BYTE_BITS) begin
                            tx_shift_r <= {tx_shift_r[6:0], 1'b1};
                            sda_oe_o <= !tx_shift_r[6];
                        end
                        if (scl_fall_c && cnt_r == BYTE_BITS) begin
                            sda_oe_o <= 1'b0;
                        end
                        if (scl_fall_c && cnt_r == ACK_BIT) begin
                            flag_r <= 1'b1;
                            scl_oe_o <= 1'b1;
                            cnt_r <= 4'h0;
                            state_r <= S_HOLD;
                            done_r <= !m_ack_r || last_r;
                            if (!m_ack_r) begin
                                status_r <= ST_ST_DATA_NACK;
                            end else if (last_r) begin
                                status_r <= ST_ST_LAST_ACK;
                            end else begin
                                status_r <= ST_ST_DATA_ACK;
                            end
                        end
                    end
                    S_HOLD: begin
                        if (!flag_r) begin
                            scl_oe_o <= 1'b0;
                            if (done_r) begin
                                state_r <= S_IDLE;
                                sda_oe_o <= 1'b0;
                                start_pending_r <= ctrl_r.start_req;
                            end else if (is_tx_r) begin
                                state_r <= S_TX;
                                tx_shift_r <= data_r;
                                sda_oe_o <= !data_r[7];
                                last_r <= !ctrl_r.ack_en;
                            end else begin
                                state_r <= S_RX;
                                ack_send_r <= ctrl_r.ack_en;
                            end
                        end
                    end
                endcase
            end
        end
    end
    // Start request and interrupt request outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_start_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            master_start_o <= start_go_c;
            irq_o <= flag_r & ctrl_r.ie;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_addr_eval;
        state_r == S_ADDR && scl_rise_c && cnt_r == BYTE_BITS - 4'h1 && ctrl_r.en;
    endsequence
    sequence s_byte_end;
        scl_fall_c && cnt_r == ACK_BIT && ctrl_r.en;
    endsequence

    a_addr_ack_off: assert property ((s_addr_eval ##0 !ctrl_r.ack_en) |=> state_r == S_IDLE)
        else $error("address taken with acknowledge off");
    a_gc_gated: assert property ((s_addr_eval ##0 !own_addr_r[0] && !own_hit_c) |=> state_r == S_IDLE)
        else $error("general call taken while disabled");
    a_read_to_tx: assert property ((s_addr_eval ##0 own_hit_c && sda_sync_r) |=> is_tx_r)
        else $error("read address did not select transmit");
    a_addr_status: assert property ((s_byte_end ##0 state_r == S_ADDR)
        |=> flag_r && status_r != ST_IDLE && scl_oe_o && state_r == S_HOLD)
        else $error("address phase ended without status");
    a_arb_status: assert property ((s_byte_end ##0 state_r == S_ADDR && is_tx_r && arb_r)
        |=> status_r == ST_ST_ARB_OWN)
        else $error("arbitration loss status wrong");
    a_last_on_off: assert property (state_r == S_TX && !ctrl_r.ack_en && ctrl_r.en
        && !start_det_c && !stop_det_c |=> last_r)
        else $error("last byte not marked");
    a_final_status: assert property ($rose(flag_r) && status_r == ST_ST_LAST_ACK |-> last_r && done_r)
        else $error("last byte status without last byte");
    a_rx_ack_drive: assert property (state_r == S_RX && scl_fall_c && cnt_r == BYTE_BITS && ctrl_r.en
        && !start_det_c |=> sda_oe_o == ack_send_r)
        else $error("receive acknowledge level wrong");
    a_drop_released: assert property (state_r == S_HOLD && !flag_r && done_r && ctrl_r.en
        |=> state_r == S_IDLE && !sda_oe_o ##1 !sda_oe_o)
        else $error("final byte did not drop out");
    a_hold_scl: assert property (state_r == S_HOLD && flag_r |-> scl_oe_o)
        else $error("SCL released while flag set");
    a_stop_report: assert property (state_r == S_RX && stop_det_c && ctrl_r.en
        |=> flag_r && status_r == ST_SR_STOP && state_r == S_IDLE)
        else $error("stop while addressed not reported");
    a_start_issue: assert property (start_pending_r && !bus_busy_r |=> master_start_o ##1 !master_start_o)
        else $error("pending start not issued");
    a_wake_match: assert property ((s_addr_eval ##0 (own_hit_c || gc_hit_c) && sleep_i) |=> wake_o)
        else $error("address match did not wake");
    a_irq_follow: assert property (flag_r && ctrl_r.ie |=> irq_o)
        else $error("interrupt request missing");
endmodule

// *** tws_bus_master.sv ***
// Behavioural two-wire bus master standing at the slave's far side
`timescale 1ns/1ps
module tws_bus_master (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    initial begin
        scl_low_o = 1'h0;
        sda_low_o = 1'h0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Release SCL, wait out a stretch, then keep it high a half period
    task automatic rise();
        scl_low_o <= 1'h0;
        do begin
            @(posedge clk_i);
        end while (scl_i !== 1'h1);
        hold(7);
    endtask
    task automatic start();
        sda_low_o <= 1'h1;
        hold(8);
        scl_low_o <= 1'h1;
        hold(8);
    endtask
    task automatic stop();
        hold(2);
        sda_low_o <= 1'h1;
        hold(6);
        rise();
        sda_low_o <= 1'h0;
        hold(8);
    endtask
    // Eight bits MSB first, then the acknowledge bit; a one releases SDA
    task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
                        output logic nq);
        logic [8:0] tx;
        logic [8:0] rx;
        tx = {d, nine};
        for (int i = 8; i >= 0; i--) begin
            hold(2);
            sda_low_o <= !tx[i];
            hold(6);
            rise();
            rx[i] = sda_i;
            scl_low_o <= 1'h1;
        end
        q = rx[8:1];
        nq = rx[0];
    endtask
endmodule

// *** testbench.sv ***
// Self-checking bench of the two-wire slave against a bus master model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("unexpected %s expected %h seen %h", nm, e, g); \
    end \
end
module testbench
    import tws_pkg::*;
;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic arb_lost_i = 1'h0;
    logic sleep_i = 1'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, wake_o, master_start_o, irq_o;
    logic m_scl, m_sda, k;
    logic [7:0] q, rq;
    wire scl_w = !(m_scl || scl_oe_o);
    wire sda_w = !(m_sda || sda_oe_o);
    int err_count = 0;
    int comparisons = 0;
    int starts = 0;
    int cycles = 0;
    tws_slave u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .arb_lost_i(arb_lost_i), .sleep_i(sleep_i), .wake_o(wake_o),
        .master_start_o(master_start_o), .irq_o(irq_o));
    tws_bus_master u_mst (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl),
        .sda_low_o(m_sda));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (master_start_o === 1'h1) begin
            starts <= starts + 1;
        end
        if (cycles == 30000) begin
            err_count++;
            test_done();
        end
    end
    task automatic wb(input logic [4:0] a, input logic we, input logic [7:0] d);
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= {24'h0, d};
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'h1);
        rq = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic ctl(input logic [7:0] d);
        wb(OFS_CTRL, 1'h1, d);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        wb(a, 1'h0, 8'h00);
        `CHK($sformatf("register %h", a), e, rq & ((a == OFS_STATUS) ? 8'hf8 : 8'hff))
    endtask
    task automatic bx(input logic [7:0] d, input logic nine);
        u_mst.xfer(d, nine, q, k);
        repeat (6) @(posedge clk_i);
    endtask
    task automatic addr(input logic [7:0] a, input logic nack);
        u_mst.start();
        bx(a, 1'h1);
        `CHK("address acknowledge", nack, k)
    endtask
    task automatic t_tx();
        rdc(OFS_OWN_ADDR, OWN_ADDR_RST);
        rdc(OFS_CTRL, CTRL_RST);
        rdc(OFS_STATUS, ST_IDLE);
        rdc(OFS_DATA, DATA_RST);
        rdc(5'h10, 8'h00);
        wb(OFS_OWN_ADDR, 1'h1, 8'h55);
        ctl(8'h45);
        addr(8'h55, 1'h0);
        rdc(OFS_STATUS, ST_ST_OWN);
        `CHK("irq", 1'h1, irq_o)
        repeat (20) @(posedge clk_i);
        `CHK("scl hold", 1'h1, scl_oe_o)
        wb(OFS_DATA, 1'h1, 8'ha5);
        ctl(8'hc5);
        repeat (2) @(posedge clk_i);
        `CHK("scl release", 1'h0, scl_oe_o)
        bx(8'hff, 1'h0);
        `CHK("first byte", 8'ha5, q)
        rdc(OFS_STATUS, ST_ST_DATA_ACK);
        wb(OFS_DATA, 1'h1, 8'h3c);
        ctl(8'h85);
        bx(8'hff, 1'h0);
        `CHK("last byte", 8'h3c, q)
        rdc(OFS_STATUS, ST_ST_LAST_ACK);
        ctl(8'hc5);
        bx(8'hff, 1'h0);
        `CHK("after last", 8'hff, q)
        u_mst.stop();
        $display("test transmit done");
    endtask
    task automatic t_arb();
        arb_lost_i <= 1'h1;
        addr(8'h55, 1'h0);
        arb_lost_i <= 1'h0;
        rdc(OFS_STATUS, ST_ST_ARB_OWN);
        wb(OFS_DATA, 1'h1, 8'h81);
        ctl(8'hc5);
        bx(8'hff, 1'h1);
        `CHK("nack byte", 8'h81, q)
        rdc(OFS_STATUS, ST_ST_DATA_NACK);
        ctl(8'he5);
        repeat (10) @(posedge clk_i);
        `CHK("start while busy", 0, starts)
        u_mst.stop();
        repeat (10) @(posedge clk_i);
        `CHK("start after stop", 1, starts)
        rdc(OFS_CTRL, 8'h45);
        $display("test arbitration done");
    endtask
    task automatic t_gc();
        addr(8'h00, 1'h0);
        rdc(OFS_STATUS, ST_SR_GC);
        ctl(8'hc5);
        bx(8'h12, 1'h1);
        `CHK("gc ack", 1'h0, k)
        rdc(OFS_STATUS, ST_GC_DATA_ACK);
        rdc(OFS_DATA, 8'h12);
        ctl(8'h85);
        bx(8'h34, 1'h1);
        `CHK("gc nack", 1'h1, k)
        rdc(OFS_STATUS, ST_GC_DATA_NACK);
        ctl(8'h85);
        u_mst.stop();
        rdc(OFS_STATUS, ST_IDLE);
        addr(8'h55, 1'h1);
        u_mst.stop();
        addr(8'h00, 1'h1);
        u_mst.stop();
        $display("test general call done");
    endtask
    task automatic t_recog();
        ctl(8'h45);
        wb(OFS_OWN_ADDR, 1'h1, 8'h54);
        addr(8'h00, 1'h1);
        u_mst.stop();
        addr(8'h56, 1'h1);
        u_mst.stop();
        sleep_i <= 1'h1;
        addr(8'h54, 1'h0);
        `CHK("wake", 1'h1, wake_o)
        rdc(OFS_STATUS, ST_SR_OWN);
        repeat (30) @(posedge clk_i);
        `CHK("wake hold", 1'h1, scl_oe_o)
        ctl(8'hc5);
        sleep_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        `CHK("wake release", 1'h0, scl_oe_o)
        u_mst.stop();
        rdc(OFS_STATUS, ST_SR_STOP);
        ctl(8'hc5);
        wb(OFS_DATA, 1'h1, 8'h77);
        rdc(OFS_CTRL, 8'h4d);
        rdc(OFS_DATA, 8'h34);
        `CHK("open drain levels", 2'h0, {scl_o, sda_o})
        $display("test recognition done");
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        t_tx();
        t_arb();
        t_gc();
        t_recog();
        test_done();
    end
endmodule
